// ### testbench/psw_ctrl_monitor.sv
// Port checker for the power-save wake controller.
// Assumes it is bound into psw_ctrl and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module psw_ctrl_monitor (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Serial and modem side
	input wire logic        rxd,
	input wire logic        tx_pending,
	input wire logic        cts_n,
	input wire logic        port_en,
	input wire logic        rx_accept,
	input wire logic        dtr_n,
	input wire logic        dtr_off_stb
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	sequence s_rx_wake;
		$rose(rxd) && cts_n;
	endsequence
	a_cts_tracks_port: assert property (cts_n == !port_en)
		else $error("cts_n and port_en disagree");
	a_tx_opens_port: assert property (tx_pending |=> port_en)
		else $error("pending output left port closed");
	a_accept_needs_port: assert property (rx_accept |-> port_en && !cts_n)
		else $error("accepting with port closed");
	a_wake_char_dropped: assert property (s_rx_wake |=> !rx_accept [*8])
		else $error("wake character accepted");
	a_dtr_pulse_once: assert property (dtr_off_stb |=> !dtr_off_stb)
		else $error("dtr off pulse too long");
	a_dtr_pulse_off: assert property (dtr_off_stb |-> dtr_n)
		else $error("dtr off pulse with line on");
	a_rd_answer: assert property (s_ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_hold: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
endmodule
`default_nettype wire

// ### testbench/psw_ctrl_tb.sv
// Self-checking bench for the power-save wake controller.
// Assumes psw_host on the serial lines and shortened timing.
`timescale 1ns/10ps
`default_nettype none
module psw_ctrl_tb;
	// ********
	// Signals
	// ********
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  s_axi_awaddr = 4'h0;
	logic [3:0]  s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        rx_char_stb = 1'b0;
	logic        tx_pending = 1'b0;
	logic        paging_stb = 1'b0;
	logic [1:0]  net_reg = 2'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [3:0]  ws = 4'hf;
	wire  [31:0] s_axi_rdata;
	wire  [1:0]  s_axi_bresp, s_axi_rresp, dtr_action;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         rxd, rts_n, dtr_n, cts_n, port_en, rx_accept, dtr_off_stb;
	int          failures = 0;
	int          checks_done = 0;
	int          n;
	logic [31:0] rv;
	logic [1:0]  rr;
	always #5 clk = ~clk;
	psw_ctrl #(.WAKE_CYC(20), .OFF_CYC(50), .OFF2G_CYC(40), .FRAME_CYC(10)) dut (.*);
	psw_host host (.clk, .rxd, .rts_n, .dtr_n);
	// ********
	// Helpers
	// ********
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task rng(input int lo, input int hi);
		chk({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask
	// Ready rises with the request and drops once the answer is taken
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tk;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= ws;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tk = s_axi_bvalid;
			rr = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		while (!tk);
		s_axi_bready <= 1'b0;
		chk(rr, er);
	endtask
	task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tk;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge clk);
			ta = s_axi_arvalid && s_axi_arready;
			tk = s_axi_rvalid;
			rv = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		while (!tk);
		s_axi_rready <= 1'b0;
		chk(rv, ed);
		chk(rr, er);
	endtask
	task wp(input logic v, input int lim);
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (port_en !== v && n < lim);
	endtask
	// ********
	// Scenarios
	// ********
	task t_regs;
		chk(cts_n, 1'b0);
		rd(4'h0, 32'h0, 2'h0);
		rd(4'h4, 32'h7d0, 2'h0);
		ws = 4'h1;
		wr(4'h4, 32'hffff0028, 2'h0);
		ws = 4'hf;
		rd(4'h4, 32'h728, 2'h0);
		wr(4'h4, 32'd39, 2'h2);
		wr(4'h4, 32'd65001, 2'h2);
		rd(4'hc, 32'h0, 2'h2);
		wr(4'h0, 32'h6, 2'h2);
		rd(4'h8, 32'hd, 2'h0);
		rd(4'h0, 32'h0, 2'h0);
	endtask
	task t_cyclic;
		wr(4'h0, 32'h1, 2'h0);
		wp(1'b0, 5);
		chk(port_en, 1'b0);
		wp(1'b1, 80);
		rng(40, 56);
		wp(1'b0, 40);
		rng(18, 23);
		host.wake();
		repeat (10) @(posedge clk);
		chk(cts_n, 1'b1);
		wp(1'b1, 30);
		rng(9, 16);
		chk(rx_accept, 1'b1);
		wr(4'h4, 32'd40, 2'h0);
		repeat (300) @(posedge clk);
		rx_char_stb <= 1'b1;
		@(posedge clk);
		rx_char_stb <= 1'b0;
		wp(1'b0, 600);
		rng(385, 420);
		@(posedge clk);
		tx_pending <= 1'b1;
		wp(1'b1, 4);
		rng(1, 2);
		@(posedge clk);
		tx_pending <= 1'b0;
	endtask
	task t_paging;
		wr(4'h0, 32'h0, 2'h0);
		net_reg <= 2'h1;
		wr(4'h0, 32'h1, 2'h0);
		wp(1'b1, 100);
		chk(port_en, 1'b0);
		@(posedge clk);
		paging_stb <= 1'b1;
		@(posedge clk);
		paging_stb <= 1'b0;
		wp(1'b1, 5);
		rng(1, 3);
		@(posedge clk);
		net_reg <= 2'h2;
		wp(1'b0, 40);
		wp(1'b1, 80);
		rng(40, 56);
		@(posedge clk);
		net_reg <= 2'h0;
	endtask
	task t_lines;
		wr(4'h0, 32'h2, 2'h0);
		host.set_rts(1'b1);
		wp(1'b0, 5);
		chk(port_en, 1'b0);
		host.set_rts(1'b0);
		wp(1'b1, 40);
		rng(19, 26);
		repeat (30) @(posedge clk);
		chk(port_en, 1'b1);
		host.set_rts(1'b1);
		wr(4'h0, 32'h27, 2'h0);
		chk(dtr_action, 2'h2);
		host.set_dtr(1'b1);
		@(posedge clk);
		#1;
		chk(dtr_off_stb, 1'b1);
		wp(1'b0, 5);
		chk(cts_n, 1'b1);
		host.set_dtr(1'b0);
		wp(1'b1, 40);
		rng(19, 26);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wp(1'b1, 3);
		t_regs;
		t_cyclic;
		t_paging;
		t_lines;
		test_done;
	end
	initial
	begin
		#200000;
		failures++;
		test_done;
	end
endmodule
bind psw_ctrl psw_ctrl_monitor mon (.*);
`default_nettype wire

// ### testbench/psw_host.sv
// Host-side model of the serial lines toward the device.
// Assumes one system clock; lines change just after its rising edge.
`timescale 1ns/10ps
`default_nettype none
module psw_host (
	// Clock
	input  wire logic clk,
	// Serial lines, low is ON on rts_n and dtr_n
	output var  logic rxd,
	output var  logic rts_n,
	output var  logic dtr_n
);
	// ********
	// Line drivers
	// ********
	initial
	begin
		rxd = 1'b1;
		rts_n = 1'b0;
		dtr_n = 1'b0;
	end
	// Dummy character: only its final rise matters, so nothing that
	// must arrive is sent until the wake time has run out
	task wake;
		@(posedge clk);
		rxd <= 1'b0;
		repeat (2) @(posedge clk);
		rxd <= 1'b1;
	endtask
	task set_rts(input logic v);
		@(posedge clk);
		rts_n <= v;
	endtask
	task set_dtr(input logic v);
		@(posedge clk);
		dtr_n <= v;
	endtask
endmodule
`default_nettype wire

// ### verilog/psw_ctrl.v
// Serial port power-save wake controller with AXI4-Lite registers.
// Assumes a UART receiver that pulses rx_char_stb per character and
// modem logic that reports paging, registration and pending output.
// Operation
// R1 - Mode selects none, cyclic, RTS, DTR
// R2 - Cyclic mode keeps port mostly disabled
// R3 - Pending outbound data enables port temporarily
// R4 - First character wakes port after 20 ms
// R5 - 2G: window at paging after 2.0 s
// R6 - 3G/LTE: 20 ms window, 2.5 s off
// R7 - Unregistered: 20 ms window, 2.5 s off
// R8 - Character holds port for programmable frames
// R9 - Timeout counted in 4.615 ms frames
// R10 - Each character restarts inactivity timer
// R11 - CTS follows port enable state
// R12 - CTS active low
// R13 - RTS mode only without hardware flow control
// R14 - RTS line off disables, on wakes
// R15 - DTR line off disables, on wakes
// R16 - DTR mode with any flow control
// R17 - DTR keeps its normal control function
// R18 - Rising receive line wakes disabled port
// R19 - Wake character is not delivered
// R20 - Data wake always on in cyclic mode; here it works only while hardware flow control is off
// R21 - Host waits 20 ms after wake character
// R22 - Host sends dummy character with autobaud
// R23 - Host sends dummy command without autobaud
// R24 - Timers restart when mode changes
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "psw_defs.vh"
module psw_ctrl #(
	parameter [31:0] WAKE_CYC  = `PSW_WAKE_US * `PSW_CLK_MHZ,
	parameter [31:0] OFF_CYC   = `PSW_OFF_US * `PSW_CLK_MHZ,
	parameter [31:0] OFF2G_CYC = `PSW_OFF2G_US * `PSW_CLK_MHZ,
	parameter [31:0] FRAME_CYC = `PSW_FRAME_US * `PSW_CLK_MHZ
)(
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// AXI4-Lite slave
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// Host serial lines
	input  wire        rxd,
	input  wire        rts_n,
	input  wire        dtr_n,
	output wire        cts_n,
	// Modem side
	input  wire        rx_char_stb,
	input  wire        tx_pending,
	input  wire        paging_stb,
	input  wire [1:0]  net_reg,
	output wire        port_en,
	output wire        rx_accept,
	output wire        dtr_off_stb,
	output wire [1:0]  dtr_action
);
	// ****************************************
	// States
	// ****************************************
	localparam [3:0] ST_OFF  = 4'h1;
	localparam [3:0] ST_WAKE = 4'h2;
	localparam [3:0] ST_WIN  = 4'h4;
	localparam [3:0] ST_ACT  = 4'h8;
	localparam [1:0] RESP_OK  = 2'h0;
	localparam [1:0] RESP_ERR = 2'h2;

	// ****************************************
	// Register bus slave
	// ****************************************
	reg        aw_got_ff;
	reg        w_got_ff;
	reg [3:0]  awaddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0]  wstrb_ff;
	reg        bvalid_ff;
	reg [1:0]  bresp_ff;
	reg        rvalid_ff;
	reg [31:0] rdata_ff;
	reg [1:0]  rresp_ff;
	reg [31:0] ctrl_ff;
	reg [15:0] tmo_ff;
	reg        refused_ff;
	wire       wr_go;
	wire [31:0] wmask;
	wire [31:0] ctrl_new;
	wire [31:0] tmo_new;
	wire        ctrl_bad;
	wire        tmo_bad;
	wire [31:0] stat_word;

	assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
	assign s_axi_wready  = ~w_got_ff & ~bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;

	// Byte lanes merge into the old value
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_lane
			assign wmask[gi*8 +: 8] = {8{wstrb_ff[gi]}};
		end
	endgenerate
	assign ctrl_new = (ctrl_ff & ~wmask) | (wdata_ff & wmask);
	assign tmo_new  = ({16'h0000, tmo_ff} & ~wmask) | (wdata_ff & wmask);
	// RTS mode and hardware flow control exclude each other
	assign ctrl_bad = (ctrl_new[`PSW_CTRL_MODE_MSB:`PSW_CTRL_MODE_LSB] == `PSW_MODE_RTS)
		& ctrl_new[`PSW_CTRL_HWFC_BIT]; // [R13]
	assign tmo_bad = (tmo_new[15:0] < `PSW_TMO_MIN) | (tmo_new[15:0] > `PSW_TMO_MAX)
		| (tmo_new[31:16] != 16'h0000); // [R8]

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			awaddr_ff  <= 4'h0;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= 2'h0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= 2'h0;
			ctrl_ff    <= `PSW_CTRL_RST;
			tmo_ff     <= `PSW_TMO_RST;
			refused_ff <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= RESP_OK;
				case ({awaddr_ff[3:2], 2'h0})
				`PSW_OFS_CTRL:
				begin
					// Refused writes keep the old setting
					if (ctrl_bad)
						bresp_ff <= RESP_ERR;
					else
						ctrl_ff <= ctrl_new & 32'h00000037;
					refused_ff <= ctrl_bad; // [R13]
				end
				`PSW_OFS_TIMEOUT:
				begin
					if (tmo_bad)
						bresp_ff <= RESP_ERR;
					else
						tmo_ff <= tmo_new[15:0]; // [R8]
				end
				`PSW_OFS_STATUS:
					bresp_ff <= RESP_OK;
				default:
					bresp_ff <= RESP_ERR;
				endcase
			end
			else if (bvalid_ff & s_axi_bready)
				bvalid_ff <= 1'b0;
			if (s_axi_arvalid & s_axi_arready)
			begin
				rvalid_ff <= 1'b1;
				rresp_ff  <= RESP_OK;
				case ({s_axi_araddr[3:2], 2'h0})
				`PSW_OFS_CTRL:    rdata_ff <= ctrl_ff;
				`PSW_OFS_TIMEOUT: rdata_ff <= {16'h0000, tmo_ff};
				`PSW_OFS_STATUS:  rdata_ff <= stat_word;
				default:
				begin
					rdata_ff <= 32'h00000000;
					rresp_ff <= RESP_ERR;
				end
				endcase
			end
			else if (rvalid_ff & s_axi_rready)
				rvalid_ff <= 1'b0;
		end
	end

	// ****************************************
	// Power-save sequencer
	// ****************************************
	wire [1:0] mode = ctrl_ff[`PSW_CTRL_MODE_MSB:`PSW_CTRL_MODE_LSB]; // [R1]
	wire       hwfc = ctrl_ff[`PSW_CTRL_HWFC_BIT];
	wire       rts_on = ~rts_n;
	wire       dtr_on = ~dtr_n;
	reg  [3:0]  st_ff;
	reg  [3:0]  nxt_st;
	reg  [31:0] tmr_ff;
	reg  [31:0] nxt_tmr;
	reg  [15:0] frm_ff;
	reg  [15:0] nxt_frm;
	reg         pgw_ff;
	reg         nxt_pgw;
	reg  [1:0]  mode_q_ff;
	reg         rxd_q_ff;
	reg         rts_q_ff;
	reg         dtr_q_ff;
	reg         cts_n_ff;
	reg         port_ff;
	reg         acc_ff;
	reg         dtro_ff;
	reg         line_on;
	reg         line_rise;
	wire        port_on;
	wire        rxd_rise = rxd & ~rxd_q_ff;
	wire        mode_chg = (mode != mode_q_ff);

	// Line that governs modes 2 and 3
	always @*
	begin
		line_on   = 1'b1;
		line_rise = 1'b0;
		case (mode)
		`PSW_MODE_RTS:
		begin
			line_on   = rts_on; // [R14]
			line_rise = rts_on & ~rts_q_ff;
		end
		`PSW_MODE_DTR:
		begin
			line_on   = dtr_on; // [R15] [R16]
			line_rise = dtr_on & ~dtr_q_ff;
		end
		default:
		begin
			line_on   = 1'b1;
			line_rise = 1'b0;
		end
		endcase
	end

	always @*
	begin
		nxt_st  = st_ff;
		nxt_tmr = tmr_ff + 32'h00000001;
		nxt_frm = frm_ff;
		nxt_pgw = pgw_ff;
		if (mode_chg)
		begin
			// A new mode starts every timer from zero
			nxt_tmr = 32'h00000000; // [R24]
			nxt_frm = 16'h0000;
			nxt_pgw = 1'b0;
			if (mode == `PSW_MODE_OFF)
				nxt_st = ST_ACT;
			else if (mode == `PSW_MODE_CYCLIC)
				nxt_st = ST_OFF; // [R2]
			else
				nxt_st = line_on ? ST_ACT : ST_OFF;
		end
		else if (mode == `PSW_MODE_OFF)
		begin
			nxt_st  = ST_ACT;
			nxt_tmr = 32'h00000000;
		end
		else if (mode == `PSW_MODE_CYCLIC)
		begin
			case (st_ff)
			ST_OFF:
			begin
				if (rxd_rise & ~hwfc)
				begin
					nxt_st  = ST_WAKE; // [R4] [R18] [R20] [R22] [R23]
					nxt_tmr = 32'h00000000;
					nxt_pgw = 1'b0;
				end
				else if (net_reg == `PSW_NET_2G)
				begin
					if (pgw_ff & paging_stb)
					begin
						nxt_st  = ST_WIN; // [R5]
						nxt_tmr = 32'h00000000;
						nxt_pgw = 1'b0;
					end
					else if (tmr_ff >= OFF2G_CYC - 32'h00000001)
					begin
						nxt_pgw = 1'b1; // [R5]
						nxt_tmr = tmr_ff;
					end
				end
				else if (tmr_ff >= OFF_CYC - 32'h00000001)
				begin
					nxt_st  = ST_WIN; // [R6] [R7]
					nxt_tmr = 32'h00000000;
				end
			end
			ST_WAKE:
			begin
				// Characters during the wake time are dropped
				if (tmr_ff >= WAKE_CYC - 32'h00000001)
				begin
					nxt_st  = ST_ACT; // [R4] [R19]
					nxt_tmr = 32'h00000000;
					nxt_frm = 16'h0000;
				end
			end
			ST_WIN:
			begin
				if (rx_char_stb | tx_pending)
				begin
					nxt_st  = ST_ACT; // [R8]
					nxt_tmr = 32'h00000000;
					nxt_frm = 16'h0000;
				end
				else if (tmr_ff >= WAKE_CYC - 32'h00000001)
				begin
					nxt_st  = ST_OFF; // [R6] [R7]
					nxt_tmr = 32'h00000000;
				end
			end
			ST_ACT:
			begin
				if (rx_char_stb | tx_pending)
				begin
					nxt_tmr = 32'h00000000; // [R10]
					nxt_frm = 16'h0000;
				end
				else if (tmr_ff >= FRAME_CYC - 32'h00000001)
				begin
					nxt_tmr = 32'h00000000; // [R9]
					nxt_frm = frm_ff + 16'h0001;
					if (frm_ff + 16'h0001 >= tmo_ff)
						nxt_st = ST_OFF; // [R8]
				end
			end
			default:
			begin
				nxt_st  = ST_OFF;
				nxt_tmr = 32'h00000000;
			end
			endcase
		end
		else
		begin
			case (st_ff)
			ST_OFF:
			begin
				nxt_tmr = 32'h00000000;
				if (line_rise)
					nxt_st = ST_WAKE; // [R14] [R15]
			end
			ST_WAKE:
			begin
				if (~line_on)
				begin
					nxt_st  = ST_OFF;
					nxt_tmr = 32'h00000000;
				end
				else if (tmr_ff >= WAKE_CYC - 32'h00000001)
				begin
					nxt_st  = ST_ACT; // [R14] [R15]
					nxt_tmr = 32'h00000000;
				end
			end
			default:
			begin
				nxt_tmr = 32'h00000000;
				nxt_st  = line_on ? ST_ACT : ST_OFF; // [R14] [R15]
			end
			endcase
		end
	end

	// Outbound data opens the port, leaving the cycle alone only while off or waking
	assign port_on = (st_ff == ST_WIN) | (st_ff == ST_ACT) | tx_pending; // [R3]

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_ff     <= ST_ACT;
			tmr_ff    <= 32'h00000000;
			frm_ff    <= 16'h0000;
			pgw_ff    <= 1'b0;
			mode_q_ff <= `PSW_MODE_OFF;
			rxd_q_ff  <= 1'b1;
			rts_q_ff  <= 1'b0;
			dtr_q_ff  <= 1'b0;
			cts_n_ff  <= 1'b1;
			port_ff   <= 1'b0;
			acc_ff    <= 1'b0;
			dtro_ff   <= 1'b0;
		end
		else
		begin
			st_ff     <= nxt_st;
			tmr_ff    <= nxt_tmr;
			frm_ff    <= nxt_frm;
			pgw_ff    <= nxt_pgw;
			mode_q_ff <= mode;
			rxd_q_ff  <= rxd;
			rts_q_ff  <= rts_on;
			dtr_q_ff  <= dtr_on;
			port_ff   <= port_on; // [R11]
			cts_n_ff  <= ~port_on; // [R12]
			// Only a fully awake receive side may pass characters
			acc_ff    <= (st_ff == ST_WIN) | (st_ff == ST_ACT); // [R19]
			dtro_ff   <= dtr_q_ff & ~dtr_on; // [R17]
		end
	end

	assign cts_n       = cts_n_ff;
	assign port_en     = port_ff;
	assign rx_accept   = acc_ff;
	assign dtr_off_stb = dtro_ff;
	assign dtr_action  = ctrl_ff[`PSW_CTRL_DTRA_MSB:`PSW_CTRL_DTRA_LSB]; // [R17]
	assign stat_word   = {26'h0000000, net_reg, refused_ff,
		st_ff == ST_ACT, st_ff == ST_WAKE, port_ff};
endmodule
`default_nettype wire

// ### verilog/psw_defs.vh
// Constants for the serial port power-save wake controller.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus.
`ifndef PSW_DEFS_VH
`define PSW_DEFS_VH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PSW_OFS_CTRL      4'h0
`define PSW_OFS_TIMEOUT   4'h4
`define PSW_OFS_STATUS    4'h8
// ****************************************
// Control register fields
// ****************************************
`define PSW_CTRL_MODE_LSB 0
`define PSW_CTRL_MODE_MSB 1
`define PSW_CTRL_HWFC_BIT 2
`define PSW_CTRL_DTRA_LSB 4
`define PSW_CTRL_DTRA_MSB 5
`define PSW_CTRL_RST      32'h00000000
// ****************************************
// Power-save modes
// ****************************************
`define PSW_MODE_OFF      2'h0
`define PSW_MODE_CYCLIC   2'h1
`define PSW_MODE_RTS      2'h2
`define PSW_MODE_DTR      2'h3
// ****************************************
// Inactivity timeout in frames
// ****************************************
`define PSW_TMO_RST       16'h07d0
`define PSW_TMO_MIN       16'h0028
`define PSW_TMO_MAX       16'hfde8
// ****************************************
// Status register fields
// ****************************************
`define PSW_STAT_PORT_BIT 0
`define PSW_STAT_WAKE_BIT 1
`define PSW_STAT_ACT_BIT  2
`define PSW_STAT_REF_BIT  3
`define PSW_STAT_NET_LSB  4
`define PSW_STAT_NET_MSB  5
// ****************************************
// Network registration codes
// ****************************************
`define PSW_NET_NONE      2'h0
`define PSW_NET_2G        2'h1
`define PSW_NET_3G4G      2'h2
// ****************************************
// Timing, in microseconds, and clock rate
// ****************************************
`define PSW_CLK_MHZ       100
`define PSW_WAKE_US       20000
`define PSW_OFF_US        2500000
`define PSW_OFF2G_US      2000000
`define PSW_FRAME_US      4615
`endif
